// [hdl/pbx_pkg.sv]
// constants for the three port bypass control channels
// assumes one 200 MHz core clock and an 8-bit internal register port
package pbx_pkg;
	localparam int NUM_CH = 3;
	localparam int NUM_PINS = 2 * NUM_CH;
	// register addresses
	localparam logic [7:0] BYPASS_CHANNEL4_CTRL = 8'h24;
	localparam logic [7:0] BYPASS_CHANNEL5_CTRL = 8'h25;
	localparam logic [7:0] BYPASS_CHANNEL6_CTRL = 8'h26;
	// field positions
	localparam int BIT_ENABLE = 7;
	localparam int BIT_SD_IRQ_EN = 6;
	localparam int BIT_FORCE_BYPASS = 1;
	localparam int BIT_SIGNAL_DETECT = 0;
	// pin pair inside a channel: even pin is signal detect, odd is bypass
	localparam int PIN_SD_OFS = 0;
	localparam int PIN_FB_OFS = 1;
	// reset values
	localparam logic RST_ENABLE = 1'b0;
	localparam logic RST_SD_IRQ_EN = 1'b0;
	localparam logic RST_FORCE_BYPASS = 1'b1;
	localparam logic RST_PIN_LEVEL = 1'b1;
	localparam logic [7:0] RST_IRQ_SRC = 8'h00;
	localparam logic [7:0] RD_UNMAPPED = 8'h00;
	// timing
	localparam int CLK_MHZ = 200;
	localparam int LOSS_MAX_NS = 400;
	localparam int LOSS_MAX_CYC = (LOSS_MAX_NS * CLK_MHZ) / 1000;
	localparam int FILT_SAMPLES = 4;
endpackage

// [hdl/pbx_pin_filt.sv]
// one pin input: two-flop synchroniser followed by a run-length filter
// assumes the pin is asynchronous to ref_clk_i
`timescale 1ns/1ps
`default_nettype none
module pbx_pin_filt #(
	parameter int SAMPLES = pbx_pkg::FILT_SAMPLES
) (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic pin_i,
	output logic filt_o
);
	import pbx_pkg::*;

	logic sync1_q, sync2_q;
	logic [SAMPLES-1:0] hist_q, hist_d;
	logic filt_q, filt_d;

	// output only moves after a full run of equal samples, so glitches
	// shorter than the run never reach the channel logic
	always_comb begin
		hist_d = {hist_q[SAMPLES-2:0], sync2_q};
		filt_d = filt_q;
		if (&hist_q) begin
			filt_d = 1'b1;
		end else if (~|hist_q) begin
			filt_d = 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sync1_q <= RST_PIN_LEVEL;
			sync2_q <= RST_PIN_LEVEL;
			hist_q <= {SAMPLES{RST_PIN_LEVEL}};
			filt_q <= RST_PIN_LEVEL;
		end else begin
			sync1_q <= pin_i;
			sync2_q <= sync1_q;
			hist_q <= hist_d;
			filt_q <= filt_d;
		end
	end

	assign filt_o = filt_q;
endmodule
`default_nettype wire

// [hdl/pbx_bypass_channels.sv]
// port bypass control channels 4..6 with their pin pairs and irq source
// assumes a host-side register port and general purpose pin settings
// supplied by the surrounding pin controller
`timescale 1ns/1ps
`default_nettype none
module pbx_bypass_channels (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	input wire logic [pbx_pkg::NUM_PINS-1:0] pin_i,
	output logic [pbx_pkg::NUM_PINS-1:0] pin_o,
	output logic [pbx_pkg::NUM_PINS-1:0] pin_oe_o,
	input wire logic [pbx_pkg::NUM_PINS-1:0] gp_out_i,
	input wire logic [pbx_pkg::NUM_PINS-1:0] gp_oe_i,
	input wire logic [pbx_pkg::NUM_PINS-1:0] bypass_sel_i,
	input wire logic irq_ack_i,
	output logic irq_n_o,
	output logic [7:0] interrupt_source_code_reg_o
);
	import pbx_pkg::*;

	// ----------------------------------------------------------------
	// pin input conditioning
	// ----------------------------------------------------------------
	logic [NUM_PINS-1:0] filt;

	genvar gp;
	generate
		for (gp = 0; gp < NUM_PINS; gp++) begin : g_filt
			pbx_pin_filt #(
				.SAMPLES(FILT_SAMPLES)
			) u_filt (
				.ref_clk_i(ref_clk_i),
				.rst_n_i(rst_n_i),
				.pin_i(pin_i[gp]),
				.filt_o(filt[gp])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// channel control registers
	// ----------------------------------------------------------------
	logic [NUM_CH-1:0] bypass_channel_enable_q, bypass_channel_enable_d;
	logic [NUM_CH-1:0] signal_detect_irq_enable_q, signal_detect_irq_enable_d;
	logic [NUM_CH-1:0] force_bypass_bit_q, force_bypass_bit_d;
	logic [NUM_CH-1:0] sd_prev_q, sd_prev_d;
	logic [NUM_CH-1:0] sd_f;
	logic [NUM_CH-1:0] sd_edge;

	always_comb begin
		bypass_channel_enable_d = bypass_channel_enable_q;
		signal_detect_irq_enable_d = signal_detect_irq_enable_q;
		force_bypass_bit_d = force_bypass_bit_q;
		for (int c = 0; c < NUM_CH; c++) begin
			sd_f[c] = filt[2*c+PIN_SD_OFS];
			sd_prev_d[c] = sd_f[c];
			sd_edge[c] = sd_f[c] ^ sd_prev_q[c];
			// only bits 7, 6 and 1 hold state; bit 0 and 5..2 drop writes
			if (reg_wr_i && reg_addr_i == BYPASS_CHANNEL4_CTRL + 8'(c)) begin
				bypass_channel_enable_d[c] = reg_wdata_i[BIT_ENABLE];
				signal_detect_irq_enable_d[c] = reg_wdata_i[BIT_SD_IRQ_EN];
				force_bypass_bit_d[c] = reg_wdata_i[BIT_FORCE_BYPASS];
			end
			// clear is a level, so it beats a concurrent write of one
			if (bypass_channel_enable_q[c] && !sd_f[c]) begin
				force_bypass_bit_d[c] = 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bypass_channel_enable_q <= {NUM_CH{RST_ENABLE}};
			signal_detect_irq_enable_q <= {NUM_CH{RST_SD_IRQ_EN}};
			force_bypass_bit_q <= {NUM_CH{RST_FORCE_BYPASS}};
			sd_prev_q <= {NUM_CH{RST_PIN_LEVEL}};
		end else begin
			bypass_channel_enable_q <= bypass_channel_enable_d;
			signal_detect_irq_enable_q <= signal_detect_irq_enable_d;
			force_bypass_bit_q <= force_bypass_bit_d;
			sd_prev_q <= sd_prev_d;
		end
	end

	// ----------------------------------------------------------------
	// pin muxing
	// ----------------------------------------------------------------
	logic [NUM_PINS-1:0] pin_q, pin_d, pin_oe_q, pin_oe_d;

	always_comb begin
		pin_d = gp_out_i;
		pin_oe_d = gp_oe_i;
		for (int c = 0; c < NUM_CH; c++) begin
			if (bypass_channel_enable_q[c]) begin
				// bypass select keeps its pin even on an enabled channel
				if (!bypass_sel_i[2*c+PIN_FB_OFS]) begin
					pin_d[2*c+PIN_FB_OFS] = force_bypass_bit_q[c];
					pin_oe_d[2*c+PIN_FB_OFS] = 1'b1;
				end
				if (!bypass_sel_i[2*c+PIN_SD_OFS]) begin
					pin_d[2*c+PIN_SD_OFS] = 1'b0;
					pin_oe_d[2*c+PIN_SD_OFS] = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pin_q <= '0;
			pin_oe_q <= '0;
		end else begin
			pin_q <= pin_d;
			pin_oe_q <= pin_oe_d;
		end
	end

	assign pin_o = pin_q;
	assign pin_oe_o = pin_oe_q;

	// ----------------------------------------------------------------
	// interrupt source
	// ----------------------------------------------------------------
	logic irq_pend_q, irq_pend_d;
	logic [7:0] src_q, src_d;
	logic irq_hit;

	// lowest channel wins when several edges land together; the others
	// still see irq low but their address is lost, as in a single slot
	always_comb begin
		irq_hit = 1'b0;
		src_d = src_q;
		for (int c = NUM_CH - 1; c >= 0; c--) begin
			if (bypass_channel_enable_q[c] && signal_detect_irq_enable_q[c]
				&& sd_edge[c]) begin
				irq_hit = 1'b1;
				src_d = BYPASS_CHANNEL4_CTRL + 8'(c);
			end
		end
		irq_pend_d = irq_pend_q;
		if (irq_ack_i) begin
			irq_pend_d = 1'b0;
		end
		if (irq_hit) begin
			irq_pend_d = 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_pend_q <= 1'b0;
			src_q <= RST_IRQ_SRC;
		end else begin
			irq_pend_q <= irq_pend_d;
			src_q <= src_d;
		end
	end

	logic irq_n_q;
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_n_q <= 1'b1;
		end else begin
			irq_n_q <= ~irq_pend_d;
		end
	end

	assign irq_n_o = irq_n_q;
	assign interrupt_source_code_reg_o = src_q;

	// ----------------------------------------------------------------
	// register read
	// ----------------------------------------------------------------
	logic [7:0] rdata_q, rdata_d;

	always_comb begin
		rdata_d = RD_UNMAPPED;
		for (int c = 0; c < NUM_CH; c++) begin
			if (reg_addr_i == BYPASS_CHANNEL4_CTRL + 8'(c)) begin
				rdata_d = 8'h00;
				rdata_d[BIT_ENABLE] = bypass_channel_enable_q[c];
				rdata_d[BIT_SD_IRQ_EN] = signal_detect_irq_enable_q[c];
				rdata_d[BIT_FORCE_BYPASS] = filt[2*c+PIN_FB_OFS];
				rdata_d[BIT_SIGNAL_DETECT] = filt[2*c+PIN_SD_OFS];
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_q <= RD_UNMAPPED;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata_o = rdata_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	localparam int LAT_MAX = LOSS_MAX_CYC;

	generate
		for (gp = 0; gp < NUM_CH; gp++) begin : g_chk
			fb_autoclr_a: assert property (@(posedge ref_clk_i)
				disable iff (!rst_n_i)
				bypass_channel_enable_q[gp] && !sd_f[gp]
				|=> !force_bypass_bit_q[gp])
				else $error("bypass bit not cleared on loss of signal");

			loss_latency_a: assert property (@(posedge ref_clk_i)
				disable iff (!rst_n_i)
				bypass_channel_enable_q[gp] && !sd_f[gp]
				&& !bypass_sel_i[2*gp+1]
				##1 bypass_channel_enable_q[gp] && !bypass_sel_i[2*gp+1]
				|-> ##[1:LAT_MAX] !pin_o[2*gp+1])
				else $error("bypass pin late after loss of signal");

			fb_pin_drive_a: assert property (@(posedge ref_clk_i)
				disable iff (!rst_n_i)
				bypass_channel_enable_q[gp] && !bypass_sel_i[2*gp+1]
				|=> pin_oe_o[2*gp+1]
				&& pin_o[2*gp+1] == $past(force_bypass_bit_q[gp]))
				else $error("bypass pin not driven from bypass bit");

			sd_input_a: assert property (@(posedge ref_clk_i)
				disable iff (!rst_n_i)
				bypass_channel_enable_q[gp] && !bypass_sel_i[2*gp]
				|=> !pin_oe_o[2*gp])
				else $error("detect pin driven on enabled channel");

			gp_pass_a: assert property (@(posedge ref_clk_i)
				disable iff (!rst_n_i)
				!bypass_channel_enable_q[gp]
				|=> pin_o[2*gp+1] == $past(gp_out_i[2*gp+1])
				&& pin_oe_o[2*gp] == $past(gp_oe_i[2*gp]))
				else $error("disabled channel disturbs its pins");

			fb_write_a: assert property (@(posedge ref_clk_i)
				disable iff (!rst_n_i)
				reg_wr_i && reg_addr_i == BYPASS_CHANNEL4_CTRL + 8'(gp)
				&& bypass_channel_enable_q[gp] && sd_f[gp]
				|=> force_bypass_bit_q[gp] == $past(reg_wdata_i[1]))
				else $error("bypass bit write not applied");

			irq_set_a: assert property (@(posedge ref_clk_i)
				disable iff (!rst_n_i)
				bypass_channel_enable_q[gp] && signal_detect_irq_enable_q[gp]
				&& sd_edge[gp] |=> !irq_n_o ##1 1'b1)
				else $error("detect edge did not raise irq");
		end
	endgenerate

	irq_code_a: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		irq_hit |=> src_q >= BYPASS_CHANNEL4_CTRL
		&& src_q <= BYPASS_CHANNEL6_CTRL)
		else $error("irq source code out of range");

	// a lone edge on the last channel must leave exactly its own address
	irq_src6_a: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		bypass_channel_enable_q[2] && signal_detect_irq_enable_q[2]
		&& sd_edge[2] && sd_edge[1:0] == 2'b00
		|=> src_q == BYPASS_CHANNEL6_CTRL)
		else $error("irq source code not the channel address");

	irq_ack_a: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		irq_ack_i && !irq_hit |=> irq_n_o)
		else $error("irq still low after acknowledge");

	no_irq_a: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		!irq_hit && irq_n_o |=> irq_n_o && $stable(src_q))
		else $error("irq without enabled detect edge");

	rd_unused_a: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		reg_rdata_o[5:2] == 4'h0)
		else $error("unused bits read non-zero");

	sd_read_a: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		reg_addr_i == BYPASS_CHANNEL5_CTRL
		|=> reg_rdata_o[0] == $past(filt[2]))
		else $error("detect bit read does not follow pin");
endmodule
`default_nettype wire

// [sim/pbx_bypass_far.sv]
// model of the external loop bypass and signal detect circuits
// assumes channel c uses pin 2c+1 for bypass and pin 2c for detect
`timescale 1ns/1ps
`default_nettype none
module pbx_bypass_far (
	input wire logic [pbx_pkg::NUM_PINS-1:0] pin_o_i,
	input wire logic [pbx_pkg::NUM_PINS-1:0] pin_oe_i,
	input wire logic [pbx_pkg::NUM_CH-1:0] sd_cmd_i,
	input wire logic [pbx_pkg::NUM_CH-1:0] pull_dn_i,
	output logic [pbx_pkg::NUM_PINS-1:0] pin_lvl_o,
	output logic [pbx_pkg::NUM_CH-1:0] bypass_mode_o
);
	import pbx_pkg::*;
	// a driven pin wins; a released bypass pin falls to its pull
	always_comb begin
		for (int c = 0; c < NUM_CH; c++) begin
			pin_lvl_o[2*c+1] = pin_oe_i[2*c+1] ? pin_o_i[2*c+1] :
				~pull_dn_i[c];
			pin_lvl_o[2*c] = pin_oe_i[2*c] ? pin_o_i[2*c] :
				sd_cmd_i[c];
			bypass_mode_o[c] = ~pin_lvl_o[2*c+1];
		end
	end
endmodule
`default_nettype wire

// [sim/port_bypass_channels_test.sv]
// self-checking bench for the three bypass channels
// assumes the far-side model resolves every pin wire
`timescale 1ns/1ps
`default_nettype none
module port_bypass_channels_test;
	import pbx_pkg::*;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic [7:0] rdata;
		logic [5:0] oe;
		logic [5:0] lvl;
	} pbx_row_t;
	logic ref_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic reg_wr_i = 1'b0;
	logic irq_ack_i = 1'b0;
	logic irq_n_o;
	logic [7:0] reg_addr_i = 8'h00;
	logic [7:0] reg_wdata_i = 8'h00;
	logic [7:0] reg_rdata_o;
	logic [7:0] src;
	logic [7:0] rd;
	logic [5:0] gp_out_i = 6'h15;
	logic [5:0] gp_oe_i = 6'h00;
	logic [5:0] bypass_sel_i = 6'h00;
	logic [5:0] pin_o;
	logic [5:0] pin_oe_o;
	logic [5:0] pin_lvl;
	logic [2:0] sd_cmd = 3'h7;
	logic [2:0] byp_mode;
	int err_count = 0;
	int total_checks = 0;
	int cycles = 0;
	int i;
	int n;
	logic [7:0] rst_rd [4] = '{8'h01, 8'h03, 8'h03, 8'h00};
	pbx_row_t rows [4] = '{
		'{8'h24, 8'h80, 8'h81, 6'h3E, 6'h15},
		'{8'h25, 8'hBE, 8'h83, 6'h3A, 6'h1D},
		'{8'h26, 8'hFF, 8'hC3, 6'h2A, 6'h3D},
		'{8'h24, 8'h82, 8'h83, 6'h2A, 6'h3F}};

	always #2.5 ref_clk_i = ~ref_clk_i;

	pbx_bypass_channels u_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
		.reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
		.reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
		.pin_i(pin_lvl), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
		.gp_out_i(gp_out_i), .gp_oe_i(gp_oe_i), .bypass_sel_i(bypass_sel_i),
		.irq_ack_i(irq_ack_i), .irq_n_o(irq_n_o),
		.interrupt_source_code_reg_o(src));
	// channel 4 bypass pin carries an external pull-down
	pbx_bypass_far u_far (.pin_o_i(pin_o), .pin_oe_i(pin_oe_o),
		.sd_cmd_i(sd_cmd), .pull_dn_i(3'h1), .pin_lvl_o(pin_lvl),
		.bypass_mode_o(byp_mode));

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [7:0] s, e);
		total_checks++;
		if (s !== e) begin
			err_count++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, d);
		@(posedge ref_clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge ref_clk_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic rd8(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk_i);
		reg_addr_i <= a;
		@(posedge ref_clk_i);
		#1 d = reg_rdata_o;
	endtask
	task automatic idle(input int k);
		repeat (k) @(posedge ref_clk_i);
		#1;
	endtask
	task automatic ack();
		@(posedge ref_clk_i);
		irq_ack_i <= 1'b1;
		@(posedge ref_clk_i);
		irq_ack_i <= 1'b0;
		idle(2);
	endtask
	task print_verdict;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// cut a hang short; the whole run needs well under 1000 cycles
	always @(posedge ref_clk_i) begin
		cycles++;
		if (cycles == 5000) begin
			err_count++;
			print_verdict();
		end
	end

	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		repeat (4) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		idle(10);
		chk("oe", {2'h0, pin_oe_o}, 8'h00);
		chk("irq", {7'h00, irq_n_o}, 8'h01);
		chk("src", src, RST_IRQ_SRC);
		for (i = 0; i < 4; i++) begin
			rd8(BYPASS_CHANNEL4_CTRL + 8'(i), rd);
			chk("rst_rd", rd, rst_rd[i]);
		end
		@(posedge ref_clk_i);
		gp_oe_i <= 6'h3F;
		wr(BYPASS_CHANNEL4_CTRL, 8'h42);
		idle(10);
		chk("gp_oe", {2'h0, pin_oe_o}, 8'h3F);
		chk("gp_lvl", {2'h0, pin_lvl}, 8'h15);
		rd8(BYPASS_CHANNEL4_CTRL, rd);
		chk("dis_rd", rd, 8'h41);
		for (i = 0; i < 4; i++) begin
			wr(rows[i].addr, rows[i].wdata);
			idle(10);
			chk("oe", {2'h0, pin_oe_o}, {2'h0, rows[i].oe});
			chk("lvl", {2'h0, pin_lvl}, {2'h0, rows[i].lvl});
			rd8(rows[i].addr, rd);
			chk("rd", rd, rows[i].rdata);
		end
		chk("norm", {5'h00, byp_mode}, 8'h00);
		@(posedge ref_clk_i);
		bypass_sel_i <= 6'h03;
		idle(3);
		chk("sel_oe", {2'h0, pin_oe_o}, 8'h2B);
		chk("mode", {5'h00, byp_mode}, 8'h01);
		@(posedge ref_clk_i);
		bypass_sel_i <= 6'h00;
		gp_oe_i <= 6'h00;
		idle(3);
		// loss of signal on channel 6 with its irq armed
		sd_cmd <= 3'h3;
		n = 0;
		while (pin_lvl[5] !== 1'b0 && n < LOSS_MAX_CYC) begin
			@(posedge ref_clk_i);
			n++;
		end
		#1;
		chk("loss", {7'h00, pin_lvl[5]}, 8'h00);
		chk("irq", {7'h00, irq_n_o}, 8'h00);
		chk("src", src, BYPASS_CHANNEL6_CTRL);
		chk("byp6", {5'h00, byp_mode}, 8'h04);
		wr(BYPASS_CHANNEL6_CTRL, 8'hC2);
		// bit 1 reads the filtered pin, which trails the pin by the filter
		idle(10);
		rd8(BYPASS_CHANNEL6_CTRL, rd);
		chk("held", rd, 8'hC0);
		ack();
		chk("ack", {7'h00, irq_n_o}, 8'h01);
		sd_cmd <= 3'h7;
		idle(12);
		chk("rise", {7'h00, irq_n_o}, 8'h00);
		ack();
		wr(BYPASS_CHANNEL6_CTRL, 8'hC2);
		idle(10);
		chk("relse", {7'h00, pin_lvl[5]}, 8'h01);
		// channel 5 loses signal with its irq off
		sd_cmd <= 3'h5;
		idle(12);
		chk("no_irq", {7'h00, irq_n_o}, 8'h01);
		chk("no_src", src, BYPASS_CHANNEL6_CTRL);
		chk("clr5", {7'h00, pin_lvl[3]}, 8'h00);
		wr(BYPASS_CHANNEL5_CTRL, 8'h81);
		idle(10);
		rd8(BYPASS_CHANNEL5_CTRL, rd);
		chk("ro_sd", rd, 8'h80);
		print_verdict();
	end
endmodule
`default_nettype wire
